// ===== rtl/ref_ladder_dac_control.sv
/*
   Control logic of the 5-bit ratiometric reference ladder: two control
   registers on a plain register port, static ladder settings, source
   decode and the digital override of the two reference output pins.
   Assumes one clock that keeps running in Sleep, a master that keeps
   strobes one cycle long and never both at once, and pad inputs that
   are synchronous to the clock.
*/
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "ref_ladder_defines.svh"

// What this block does
// R1: Enable bit 7 turns converter on
// R2: Five-bit level code picks one of 32
// R3: Bits 5 and 4 route level to pins
// R4: Routed pin loses driver, detector, pull-up, drive
// R5: Routed pin digital read returns zero
// R6: Source select: supply, external pin, fixed, reserved
// R7: Negative source select always reads zero
// R8: Unimplemented bits read as zero
// R9: Works in Sleep, wake keeps control register
// R10: Reset disables, unroutes pins, clears level
// R11: Ladder settings static, change on write only
module ref_ladder_dac_control (
   input  wire logic                         ref_clk_in,
   input  wire logic                         rst_in,
   input  wire logic [`REF_ADDR_W-1:0]       reg_addr_in,
   input  wire logic [`REF_DATA_W-1:0]       reg_wdata_in,
   input  wire logic                         reg_wr_in,
   input  wire logic                         reg_rd_in,
   output logic      [`REF_DATA_W-1:0]       reg_rdata_out,
   input  wire logic                         sleep_in,
   output ref_ladder_pkg::ladder_ctrl_t      ladder_out,
   output ref_ladder_pkg::src_onehot_t       source_switch_out,
   output logic      [`REF_PINS-1:0]         analog_connect_out,
   input  wire ref_ladder_pkg::pin_drive_t   port_drive_in  [`REF_PINS],
   input  wire logic [`REF_PINS-1:0]         pad_in,
   output ref_ladder_pkg::pin_drive_t        pad_drive_out  [`REF_PINS],
   output logic      [`REF_PINS-1:0]         port_read_out
);
   import ref_ladder_pkg::*;

   // Register state
   logic                    converter_enable_ff;
   logic                    pin_a_output_enable_ff;
   logic                    pin_b_output_enable_ff;
   pos_src_t                positive_source_select_ff;
   logic [`LEVEL_W-1:0]     level_code_ff;
   logic [`REF_DATA_W-1:0]  rdata_ff;
   logic [`REF_DATA_W-1:0]  nxt_rdata;
   logic                    ctrl_wr;
   logic                    level_wr;
   logic                    ctrl_rd;
   logic                    level_rd;
   logic [`REF_DATA_W-1:0]  ctrl_view;
   logic [`REF_DATA_W-1:0]  level_view;

   // Address match, used for every strobe decode
   function automatic logic addr_hit(input logic [`REF_ADDR_W-1:0] addr,
                                     input logic [`REF_ADDR_W-1:0] target);
      addr_hit = (addr == target);
   endfunction

   // Strobe decode
   assign ctrl_wr  = reg_wr_in & addr_hit(reg_addr_in, `REF_CTRL_ADDR);
   assign level_wr = reg_wr_in & addr_hit(reg_addr_in, `REF_LEVEL_ADDR);
   assign ctrl_rd  = reg_rd_in & addr_hit(reg_addr_in, `REF_CTRL_ADDR);
   assign level_rd = reg_rd_in & addr_hit(reg_addr_in, `REF_LEVEL_ADDR);

   // Enable bit, cleared by reset only or by a write
   always_ff @(posedge ref_clk_in or posedge rst_in) begin // R9
      if (rst_in) begin
         converter_enable_ff <= `BIT_CLEAR; // R10
      end else if (ctrl_wr) begin
         converter_enable_ff <= reg_wdata_in[`CTRL_EN_BIT]; // R1
      end
   end

   // Pin routing enables
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_a_output_enable_ff <= `BIT_CLEAR; // R10
         pin_b_output_enable_ff <= `BIT_CLEAR; // R10
      end else if (ctrl_wr) begin
         pin_a_output_enable_ff <= reg_wdata_in[`CTRL_OEA_BIT]; // R3
         pin_b_output_enable_ff <= reg_wdata_in[`CTRL_OEB_BIT]; // R3
      end
   end

   // Positive source select; sleep has no effect on it
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         positive_source_select_ff <= pos_src_t'(`PSS_RESET);
      end else if (ctrl_wr) begin
         positive_source_select_ff <= pos_src_t'(reg_wdata_in[`CTRL_PSS_HI:`CTRL_PSS_LO]); // R6
      end
   end

   // Level code
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         level_code_ff <= `LEVEL_RESET; // R10
      end else if (level_wr) begin
         level_code_ff <= reg_wdata_in[`LEVEL_HI:`LEVEL_LO]; // R2
      end
   end

   // Read views; empty and negative-select bits stay zero
   always_comb begin
      ctrl_view                             = `READ_ZERO; // R8
      ctrl_view[`CTRL_EN_BIT]               = converter_enable_ff;
      ctrl_view[`CTRL_OEA_BIT]              = pin_a_output_enable_ff;
      ctrl_view[`CTRL_OEB_BIT]              = pin_b_output_enable_ff;
      ctrl_view[`CTRL_PSS_HI:`CTRL_PSS_LO]  = positive_source_select_ff;
      ctrl_view[`CTRL_NSS_BIT]              = `BIT_CLEAR; // R7
      level_view                            = `READ_ZERO; // R8
      level_view[`LEVEL_HI:`LEVEL_LO]       = level_code_ff;
   end

   // Read data mux; unmapped reads answer zero
   always_comb begin
      nxt_rdata = `READ_ZERO;
      if (ctrl_rd) begin
         nxt_rdata = ctrl_view;
      end else if (level_rd) begin
         nxt_rdata = level_view;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_ff <= `READ_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_out = rdata_ff;

   // Static settings straight from the registers
   assign ladder_out.converter_enable       = converter_enable_ff; // R11
   assign ladder_out.positive_source_select = positive_source_select_ff; // R11
   assign ladder_out.level_code             = level_code_ff; // R11

   // Pin routing
   assign analog_connect_out[`PIN_A] = pin_a_output_enable_ff; // R3
   assign analog_connect_out[`PIN_B] = pin_b_output_enable_ff; // R3

   // Ladder top switch decode
   ref_source_decode u_source_decode (
      .sel_in     (positive_source_select_ff),
      .onehot_out (source_switch_out)
   ); // R6

   // Digital override of each routed pin
   for (genvar p = 0; p < `REF_PINS; p++) begin : g_pin
      ref_pin_override u_pin_override (
         .analog_route_in  (analog_connect_out[p]),
         .digital_in       (port_drive_in[p]),
         .pad_in           (pad_in[p]),
         .pad_out          (pad_drive_out[p]),
         .digital_read_out (port_read_out[p])
      ); // R4 R5
   end

   // Checks on register behaviour
   property p_enable_write;
      @(posedge ref_clk_in) disable iff (rst_in)
      ctrl_wr |=> (ladder_out.converter_enable == $past(reg_wdata_in[`CTRL_EN_BIT]));
   endproperty
   a_enable_write: assert property (p_enable_write) // R1
      else $error("enable bit did not follow control write");

   property p_level_write;
      @(posedge ref_clk_in) disable iff (rst_in)
      level_wr |=> (ladder_out.level_code == $past(reg_wdata_in[`LEVEL_HI:`LEVEL_LO]))
                   ##1 (reg_rdata_out == {3'h0, ladder_out.level_code} || !$past(level_rd));
   endproperty
   a_level_write: assert property (p_level_write) // R2
      else $error("level code did not follow level write");

   property p_route_write;
      @(posedge ref_clk_in) disable iff (rst_in)
      ctrl_wr |=> (analog_connect_out ==
                   {$past(reg_wdata_in[`CTRL_OEB_BIT]), $past(reg_wdata_in[`CTRL_OEA_BIT])});
   endproperty
   a_route_write: assert property (p_route_write) // R3
      else $error("pin routing did not follow control write");

   property p_pin_a_override;
      @(posedge ref_clk_in) disable iff (rst_in)
      analog_connect_out[`PIN_A] |-> (pad_drive_out[`PIN_A].drive_oe_n
                                      && !pad_drive_out[`PIN_A].pullup_en
                                      && !pad_drive_out[`PIN_A].current_drive_en);
   endproperty
   a_pin_a_override: assert property (p_pin_a_override) // R4
      else $error("routed pin A still has digital drive");

   property p_pin_b_override;
      @(posedge ref_clk_in) disable iff (rst_in)
      analog_connect_out[`PIN_B] |-> (pad_drive_out[`PIN_B].drive_oe_n
                                      && !pad_drive_out[`PIN_B].pullup_en
                                      && !pad_drive_out[`PIN_B].current_drive_en);
   endproperty
   a_pin_b_override: assert property (p_pin_b_override) // R4
      else $error("routed pin B still has digital drive");

   property p_pin_read_zero;
      @(posedge ref_clk_in) disable iff (rst_in)
      ((port_read_out & analog_connect_out) == '0)
      && ((port_read_out & ~analog_connect_out) == (pad_in & ~analog_connect_out));
   endproperty
   a_pin_read_zero: assert property (p_pin_read_zero) // R5
      else $error("routed pin digital read was not zero");

   property p_source_decode;
      @(posedge ref_clk_in) disable iff (rst_in)
      (source_switch_out.supply          == (ladder_out.positive_source_select == PSS_SUPPLY))
      && (source_switch_out.ext_pin      == (ladder_out.positive_source_select == PSS_EXT_PIN))
      && (source_switch_out.fixed_reference
          == (ladder_out.positive_source_select == PSS_FIXED));
   endproperty
   a_source_decode: assert property (p_source_decode) // R6
      else $error("positive source switches wrong");

   property p_ctrl_read_zero_bits;
      @(posedge ref_clk_in) disable iff (rst_in)
      ctrl_rd |=> (reg_rdata_out[`CTRL_NSS_BIT] == `BIT_CLEAR)
                  && (reg_rdata_out[`CTRL_SPARE_HI_BIT] == `BIT_CLEAR)
                  && (reg_rdata_out[`CTRL_SPARE_LO_BIT] == `BIT_CLEAR)
                  && (reg_rdata_out[`CTRL_EN_BIT] == $past(converter_enable_ff));
   endproperty
   a_ctrl_read_zero_bits: assert property (p_ctrl_read_zero_bits) // R7 R8
      else $error("control read showed a set empty bit");

   property p_level_read_zero_bits;
      @(posedge ref_clk_in) disable iff (rst_in)
      level_rd |=> (reg_rdata_out[`LEVEL_SPARE_HI:`LEVEL_SPARE_LO] == '0)
                   && (reg_rdata_out[`LEVEL_HI:`LEVEL_LO] == $past(level_code_ff));
   endproperty
   a_level_read_zero_bits: assert property (p_level_read_zero_bits) // R8
      else $error("level read showed a set empty bit");

   property p_sleep_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      (sleep_in && !reg_wr_in) |=> ($stable(ladder_out) && $stable(analog_connect_out));
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) // R9
      else $error("settings changed during sleep without a write");

   property p_reset_clear;
      @(posedge ref_clk_in)
      $fell(rst_in) |-> (!ladder_out.converter_enable && (analog_connect_out == '0)
                         && (ladder_out.level_code == `LEVEL_RESET));
   endproperty
   a_reset_clear: assert property (p_reset_clear) // R10
      else $error("reset left the converter set up");

   property p_static_settings;
      @(posedge ref_clk_in) disable iff (rst_in)
      !(ctrl_wr || level_wr) |=> $stable(ladder_out);
   endproperty
   a_static_settings: assert property (p_static_settings) // R11
      else $error("ladder settings moved without a write");

   property p_read_only_after;
      @(posedge ref_clk_in) disable iff (rst_in)
      !reg_rd_in |=> (reg_rdata_out == `READ_ZERO);
   endproperty
   a_read_only_after: assert property (p_read_only_after)
      else $error("read data stood outside its cycle");

   // Checks on field holding, pass-through and reset
   property p_source_write;
      @(posedge ref_clk_in) disable iff (rst_in)
      ctrl_wr |=> (ladder_out.positive_source_select
                   == $past(reg_wdata_in[`CTRL_PSS_HI:`CTRL_PSS_LO]));
   endproperty
   a_source_write: assert property (p_source_write) // R6
      else $error("source select did not follow control write");

   property p_level_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      !level_wr |=> $stable(ladder_out.level_code);
   endproperty
   a_level_hold: assert property (p_level_hold) // R11
      else $error("level code moved without a level write");

   property p_route_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      !ctrl_wr |=> ($stable(analog_connect_out) && $stable(ladder_out.converter_enable));
   endproperty
   a_route_hold: assert property (p_route_hold) // R3
      else $error("routing or enable moved without a control write");

   property p_unmapped_read;
      @(posedge ref_clk_in) disable iff (rst_in)
      (reg_rd_in && !ctrl_rd && !level_rd) |=> (reg_rdata_out == `READ_ZERO);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) // R8
      else $error("unmapped read returned data");

   property p_pin_a_pass;
      @(posedge ref_clk_in) disable iff (rst_in)
      !analog_connect_out[`PIN_A] |-> (pad_drive_out[`PIN_A] == port_drive_in[`PIN_A]);
   endproperty
   a_pin_a_pass: assert property (p_pin_a_pass) // R3
      else $error("unrouted pin A lost its port drive");

   property p_pin_b_pass;
      @(posedge ref_clk_in) disable iff (rst_in)
      !analog_connect_out[`PIN_B] |-> (pad_drive_out[`PIN_B] == port_drive_in[`PIN_B]);
   endproperty
   a_pin_b_pass: assert property (p_pin_b_pass) // R3
      else $error("unrouted pin B lost its port drive");

   property p_reset_rdata;
      @(posedge ref_clk_in)
      $fell(rst_in) |-> ((reg_rdata_out == `READ_ZERO)
                         && (ladder_out.positive_source_select == PSS_SUPPLY));
   endproperty
   a_reset_rdata: assert property (p_reset_rdata) // R10
      else $error("reset left read data or source select set");

   // Main scenarios
   property p_cov_enable_route;
      @(posedge ref_clk_in) disable iff (rst_in)
      ladder_out.converter_enable && (analog_connect_out == 2'h3);
   endproperty
   c_cov_enable_route: cover property (p_cov_enable_route);

   property p_cov_full_level;
      @(posedge ref_clk_in) disable iff (rst_in)
      level_wr ##1 (ladder_out.level_code == 5'h1F) ##1 level_rd;
   endproperty
   c_cov_full_level: cover property (p_cov_full_level);

   property p_cov_fixed_source;
      @(posedge ref_clk_in) disable iff (rst_in)
      source_switch_out.fixed_reference && sleep_in;
   endproperty
   c_cov_fixed_source: cover property (p_cov_fixed_source);

   property p_cov_back_to_back;
      @(posedge ref_clk_in) disable iff (rst_in)
      ctrl_wr ##1 ctrl_rd;
   endproperty
   c_cov_back_to_back: cover property (p_cov_back_to_back);

endmodule // ref_ladder_dac_control

// ===== rtl/ref_ladder_defines.svh
/*
   Constants of the reference ladder control block: register offsets,
   field positions, reset values and widths.
   Assumes it is included by bare name wherever a constant is used.
*/
`ifndef REF_LADDER_DEFINES_SVH
`define REF_LADDER_DEFINES_SVH

// Register offsets on the plain register port
`define REF_ADDR_W        8
`define REF_DATA_W        8
`define REF_CTRL_ADDR     8'h00
`define REF_LEVEL_ADDR    8'h01

// Control register fields
`define CTRL_EN_BIT       7
`define CTRL_OEA_BIT      5
`define CTRL_OEB_BIT      4
`define CTRL_PSS_HI       3
`define CTRL_PSS_LO       2
`define CTRL_NSS_BIT      0
`define CTRL_SPARE_HI_BIT 6
`define CTRL_SPARE_LO_BIT 1

// Level register fields
`define LEVEL_W           5
`define LEVEL_HI          4
`define LEVEL_LO          0
`define LEVEL_SPARE_HI    7
`define LEVEL_SPARE_LO    5

// Reset values and fill
`define CTRL_RESET        8'h00
`define LEVEL_RESET       5'h00
`define PSS_RESET         2'h0
`define READ_ZERO         8'h00
`define BIT_CLEAR         1'b0
`define BIT_SET           1'b1

// Pins that can carry the ladder level
`define REF_PINS          2
`define PIN_A             0
`define PIN_B             1

`endif

// ===== rtl/ref_ladder_pkg.sv
/*
   Types of the reference ladder control block.
   Assumes ref_ladder_defines.svh is on the include path.
*/
`include "ref_ladder_defines.svh"

package ref_ladder_pkg;

   // Positive source choices of the ladder top
   typedef enum logic [1:0] {
      PSS_SUPPLY   = 2'b00,
      PSS_EXT_PIN  = 2'b01,
      PSS_FIXED    = 2'b10,
      PSS_RESERVED = 2'b11
   } pos_src_t;

   // Static settings presented to the analog ladder
   typedef struct packed {
      logic                  converter_enable;
      pos_src_t              positive_source_select;
      logic [`LEVEL_W-1:0]   level_code;
   } ladder_ctrl_t;

   // One-hot switch controls for the ladder top
   typedef struct packed {
      logic supply;
      logic ext_pin;
      logic fixed_reference;
   } src_onehot_t;

   // Pad-side controls of one pin
   typedef struct packed {
      logic drive_val;
      logic drive_oe_n;
      logic pullup_en;
      logic current_drive_en;
   } pin_drive_t;

endpackage : ref_ladder_pkg

// ===== rtl/ref_pin_override.sv
/*
   Override of one pin's digital functions while it carries the level.
   Assumes digital controls come from the port logic of the device.
*/
`timescale 1ns/1ns
`include "ref_ladder_defines.svh"

module ref_pin_override (
   input  wire logic                        analog_route_in,
   input  wire ref_ladder_pkg::pin_drive_t  digital_in,
   input  wire logic                        pad_in,
   output ref_ladder_pkg::pin_drive_t       pad_out,
   output logic                             digital_read_out
);
   import ref_ladder_pkg::*;

   // Routed pin: driver off, pull-up off, current drive off
   always_comb begin
      pad_out = digital_in;
      if (analog_route_in) begin
         pad_out.drive_val        = `BIT_CLEAR;
         pad_out.drive_oe_n       = `BIT_SET;
         pad_out.pullup_en        = `BIT_CLEAR;
         pad_out.current_drive_en = `BIT_CLEAR;
      end
   end

   // Routed pin reads as zero, threshold detector cut off
   assign digital_read_out = analog_route_in ? `BIT_CLEAR : pad_in;

endmodule // ref_pin_override

// ===== rtl/ref_source_decode.sv
/*
   Decoder from the positive source code to one-hot ladder switches.
   Assumes the code comes from a register; reserved code closes none.
*/
`timescale 1ns/1ns
`include "ref_ladder_defines.svh"

module ref_source_decode (
   input  wire ref_ladder_pkg::pos_src_t    sel_in,
   output ref_ladder_pkg::src_onehot_t      onehot_out
);
   import ref_ladder_pkg::*;

   // One switch per legal code, none for the reserved one
   always_comb begin
      onehot_out = '0;
      unique case (sel_in)
         PSS_SUPPLY   : onehot_out.supply          = `BIT_SET;
         PSS_EXT_PIN  : onehot_out.ext_pin         = `BIT_SET;
         PSS_FIXED    : onehot_out.fixed_reference = `BIT_SET;
         PSS_RESERVED : onehot_out                 = '0;
      endcase
   end

endmodule // ref_source_decode

// ===== sim/ref_ladder_dac_control_test.sv
/*
   Self-checking bench of the reference ladder control block.
   Assumes the design files and ref_pad_model are compiled first.
*/
`timescale 1ns/1ns
`include "ref_ladder_defines.svh"

module ref_ladder_dac_control_test;
   import ref_ladder_pkg::*;

   logic         ref_clk_in = 1'b0;
   logic         rst_in     = 1'b1;
   logic [7:0]   reg_addr   = 8'h00;
   logic [7:0]   reg_wdata  = 8'h00;
   logic         reg_wr     = 1'b0;
   logic         reg_rd     = 1'b0;
   logic         sleep      = 1'b0;
   logic [7:0]   rdata;
   ladder_ctrl_t ladder;
   src_onehot_t  sw;
   logic [1:0]   conn;
   logic [1:0]   pad;
   logic [1:0]   port_read;
   pin_drive_t   req       [`REF_PINS] = '{4'hB, 4'hB};
   pin_drive_t   port_drive[`REF_PINS];
   pin_drive_t   pad_drive [`REF_PINS];
   logic [2:0]   src_exp   [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
   int           err_count = 0;
   int           tests_run = 0;
   int           cycles    = 0;

   always #10 ref_clk_in = ~ref_clk_in;

   ref_ladder_dac_control dut (
      .ref_clk_in        (ref_clk_in),
      .rst_in            (rst_in),
      .reg_addr_in       (reg_addr),
      .reg_wdata_in      (reg_wdata),
      .reg_wr_in         (reg_wr),
      .reg_rd_in         (reg_rd),
      .reg_rdata_out     (rdata),
      .sleep_in          (sleep),
      .ladder_out        (ladder),
      .source_switch_out (sw),
      .analog_connect_out(conn),
      .port_drive_in     (port_drive),
      .pad_in            (pad),
      .pad_drive_out     (pad_drive),
      .port_read_out     (port_read)
   );

   ref_pad_model pads (
      .clk_in        (ref_clk_in),
      .rst_in        (rst_in),
      .req_in        (req),
      .pad_drive_in  (pad_drive),
      .port_drive_out(port_drive),
      .pad_out       (pad)
   );

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One-cycle write strobe
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk_in);
      reg_wr    <= 1'b0;
      #1;
   endtask

   // Read; data only in the cycle after the strobe, zero after
   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk_in);
      reg_rd   <= 1'b0;
      #1;
      check(rdata, exp);
      @(posedge ref_clk_in);
      #1;
      check(rdata, 8'h00);
   endtask

   // Settings and routing cleared by reset, supply switch closed
   task automatic check_cleared();
      check(ladder, 8'h00);
      check({5'h00, sw}, 8'h04);
      check({6'h00, conn}, 8'h00);
      check({4'h0, pad_drive[0]}, {4'h0, req[0]});
   endtask

   // Hang guard
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      #1;
      check_cleared();
      read_check(`REF_CTRL_ADDR, 8'h00);
      read_check(`REF_LEVEL_ADDR, 8'h00);
      // All writable bits set; holes and negative select stay zero
      write_reg(`REF_CTRL_ADDR, 8'hFF);
      check(ladder[7], 1'b1);
      check({6'h00, conn}, 8'h03);
      read_check(`REF_CTRL_ADDR, 8'hBC);
      write_reg(`REF_LEVEL_ADDR, 8'hFF);
      read_check(`REF_LEVEL_ADDR, 8'h1F);
      write_reg(`REF_CTRL_ADDR, 8'h00);
      check(ladder[7], 1'b0);
      // Every level code
      for (int i = 0; i < 32; i++) begin
         write_reg(`REF_LEVEL_ADDR, 8'(i));
         check({3'h0, ladder.level_code}, 8'(i));
      end
      read_check(`REF_LEVEL_ADDR, 8'h1F);
      // Every source code
      for (int i = 0; i < 4; i++) begin
         write_reg(`REF_CTRL_ADDR, 8'h80 | 8'(i << 2));
         check({5'h00, sw}, {5'h00, src_exp[i]});
         read_check(`REF_CTRL_ADDR, 8'h80 | 8'(i << 2));
      end
      // Pin A routed, pin B left to the port logic
      write_reg(`REF_CTRL_ADDR, 8'hA0);
      repeat (3) begin
         check({4'h0, pad_drive[0]}, 8'h04);
         check({4'h0, pad_drive[1]}, 8'h0B);
         check({6'h00, port_read}, 8'h02);
         @(posedge ref_clk_in);
         #1;
      end
      // Pin B routed, pin A undriven and floating
      @(posedge ref_clk_in);
      req[0] <= 4'h4;
      write_reg(`REF_CTRL_ADDR, 8'h90);
      repeat (3) begin
         check({4'h0, pad_drive[1]}, 8'h04);
         check({4'h0, pad_drive[0]}, 8'h04);
         check({6'h00, port_read}, {7'h00, pad[0]});
         @(posedge ref_clk_in);
         #1;
      end
      // Settings hold through Sleep
      write_reg(`REF_CTRL_ADDR, 8'hB8);
      write_reg(`REF_LEVEL_ADDR, 8'h0A);
      @(posedge ref_clk_in);
      sleep <= 1'b1;
      repeat (20) @(posedge ref_clk_in);
      #1;
      check(ladder, 8'hCA);
      check({5'h00, sw}, 8'h01);
      check({6'h00, conn}, 8'h03);
      @(posedge ref_clk_in);
      sleep <= 1'b0;
      read_check(`REF_CTRL_ADDR, 8'hB8);
      // Unmapped address changes nothing and reads zero
      write_reg(8'h02, 8'hFF);
      check(ladder, 8'hCA);
      read_check(8'h02, 8'h00);
      read_check(8'hFF, 8'h00);
      // Write then read with no gap between strobes
      @(posedge ref_clk_in);
      reg_wr    <= 1'b1;
      reg_addr  <= `REF_CTRL_ADDR;
      reg_wdata <= 8'h98;
      @(posedge ref_clk_in);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd    <= 1'b0;
      #1;
      check(rdata, 8'h98);
      // Reset in mid-run
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      #1;
      check_cleared();
      @(posedge ref_clk_in);
      rst_in <= 1'b0;
      read_check(`REF_CTRL_ADDR, 8'h00);
      read_check(`REF_LEVEL_ADDR, 8'h00);
      summarize();
   end
endmodule // ref_ladder_dac_control_test

// ===== sim/ref_pad_model.sv
/*
   Pad and port-logic model for the two reference output pins.
   Assumes the bench sets the port-logic requests; pad levels follow
   the pad controls that the block hands out.
*/
`timescale 1ns/1ns
`include "ref_ladder_defines.svh"

module ref_pad_model (
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   input  wire ref_ladder_pkg::pin_drive_t  req_in        [`REF_PINS],
   input  wire ref_ladder_pkg::pin_drive_t  pad_drive_in  [`REF_PINS],
   output ref_ladder_pkg::pin_drive_t       port_drive_out [`REF_PINS],
   output logic [`REF_PINS-1:0]             pad_out
);
   import ref_ladder_pkg::*;

   logic [`REF_PINS-1:0] float_ff;

   // Undriven pad wanders every cycle, never keeps a stale level
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         float_ff <= 2'h1;
      end else begin
         float_ff <= ~float_ff;
      end
   end

   // Pad level: driver first, then pull-up, else floating
   always_comb begin
      for (int i = 0; i < `REF_PINS; i++) begin
         port_drive_out[i] = req_in[i];
         if (!pad_drive_in[i].drive_oe_n) begin
            pad_out[i] = pad_drive_in[i].drive_val;
         end else if (pad_drive_in[i].pullup_en) begin
            pad_out[i] = 1'b1;
         end else begin
            pad_out[i] = float_ff[i];
         end
      end
   end
endmodule // ref_pad_model
